/* design/tcc_channel.sv */
// One transmit channel: clock edge sampling, all-ones override and error-insert pulse.
`timescale 1ns/1ns
`default_nettype none
module tcc_channel (
    input  wire logic               sys_clk,
    input  wire logic               reset_n,
    input  wire tcc_pkg::tcc_cfg_s  cfg,
    input  wire logic               line_clk_sync,
    input  wire tcc_pkg::tcc_rail_s rail_sync,
    output var  tcc_pkg::tcc_rail_s line_out,
    output var  logic               line_strobe,
    output var  logic               error_inject,
    output var  logic               buildout_enable,
    output var  logic               monitor_internal
);

    typedef struct packed {
        logic               clk_prev;
        logic               err_prev;
        logic               inject_pend;
        logic               inject;
        logic               strobe;
        tcc_pkg::tcc_rail_s data;
        logic               buildout;
        logic               mon;
    } tcc_ch_state_s;

    tcc_ch_state_s state_reg;
    tcc_ch_state_s state_next;

    always_comb begin
        logic rise;
        logic fall;
        logic take;
        rise = line_clk_sync & ~state_reg.clk_prev;
        fall = ~line_clk_sync & state_reg.clk_prev;
        take = cfg.edge_rising ? rise : fall;
        state_next = state_reg;
        state_next.clk_prev = line_clk_sync;
        state_next.err_prev = cfg.err_insert;
        state_next.inject = 1'b0;
        state_next.strobe = take;
        // An insert request waits for the next bit slot so that exactly one bit is hit.
        if (cfg.err_insert && !state_reg.err_prev && cfg.prbs_gen_en && cfg.prbs_rx_en) begin
            state_next.inject_pend = 1'b1;
        end
        if (take) begin
            if (cfg.all_ones) begin
                state_next.data = '{pos: 1'b1, neg: 1'b0};
            end else begin
                state_next.data = rail_sync;
            end
            if (state_reg.inject_pend) begin
                state_next.inject = 1'b1;
                state_next.inject_pend = 1'b0;
            end
        end
        if (!(cfg.prbs_gen_en && cfg.prbs_rx_en)) begin
            state_next.inject_pend = 1'b0;
        end
        state_next.buildout = cfg.buildout_on & ~cfg.e3_mode;
        state_next.mon = cfg.mon_internal;
        if (!reset_n) begin
            state_next = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        state_reg <= state_next;
    end

    assign line_out = state_reg.data;
    assign line_strobe = state_reg.strobe;
    assign error_inject = state_reg.inject;
    assign buildout_enable = state_reg.buildout;
    assign monitor_internal = state_reg.mon;

endmodule
`default_nettype wire

/* design/tcc_top.sv */
// Three-channel transmit control register bank with Wishbone slave and rail sampling.
//
// Overview of operation
// - Each 0 to 1 change of error-insert corrupts exactly one generator bit.
// - Error-insert acts only when generator and receiver of the channel are enabled.
// - All-ones set replaces system data with continuous unframed all-ones.
// - All-ones clear forwards system data unchanged to the line.
// - Edge select 0 samples rails on falling clock edge, 1 on rising.
// - Edge selection applies independently per channel.
// - Build-out bit enables or disables the channel pulse shaper.
// - Build-out is ignored in E3 line rate.
// - Transmit control decodes at indices 0x04, 0x0c and 0x14.
// - Monitor select picks external inputs at 0, internal pads at 1.
`timescale 1ns/1ns
`default_nettype none
module tcc_top (
    input  wire logic                       sys_clk,
    input  wire logic                       reset_n,
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    input  wire logic                       wb_we_i,
    input  wire logic [31:0]                wb_adr_i,
    input  wire logic [3:0]                 wb_sel_i,
    input  wire logic [31:0]                wb_dat_i,
    output var  logic [31:0]                wb_dat_o,
    output var  logic                       wb_ack_o,
    input  wire logic [2:0]                 transmit_line_clock,
    input  wire logic [2:0]                 positive_rail_input,
    input  wire logic [2:0]                 negative_rail_input,
    output var  logic [2:0]                 line_pos,
    output var  logic [2:0]                 line_neg,
    output var  logic [2:0]                 line_strobe,
    output var  logic [2:0]                 error_inject,
    output var  logic [2:0]                 buildout_enable,
    output var  logic [2:0]                 monitor_internal
);

    typedef struct packed {
        logic [2:0][7:0]    tx_ctrl;
        logic [2:0][7:0]    rx_ctrl;
        logic [2:0][7:0]    mode;
        logic               ack;
        logic [31:0]        rdata;
        logic [2:0]         clk_s1;
        logic [2:0]         clk_s2;
        logic [2:0]         pos_s1;
        logic [2:0]         pos_s2;
        logic [2:0]         neg_s1;
        logic [2:0]         neg_s2;
    } tcc_top_state_s;

    tcc_top_state_s state_reg;
    tcc_top_state_s state_next;

    // Kind of register a word index selects, and for which channel.
    function automatic logic [3:0] reg_decode(input logic [31:0] adr);
        logic [29:0] idx;
        logic [3:0]  res;
        idx = adr[31:2];
        res = 4'h0;
        for (int c = 0; c < tcc_pkg::NUM_CH; c++) begin
            if (idx == 30'(tcc_pkg::TX_CTRL_IDX_CH0 + 8'(c) * tcc_pkg::CH_STRIDE)) begin
                res = {2'b01, 2'(c)};
            end
            if (idx == 30'(tcc_pkg::RX_CTRL_IDX_CH0 + 8'(c) * tcc_pkg::CH_STRIDE)) begin
                res = {2'b10, 2'(c)};
            end
            if (idx == 30'(tcc_pkg::MODE_IDX_CH0 + 8'(c) * tcc_pkg::CH_STRIDE)) begin
                res = {2'b11, 2'(c)};
            end
        end
        return res;
    endfunction

    always_comb begin
        logic [3:0] dec;
        logic [1:0] ch;
        logic       req;
        dec = reg_decode(wb_adr_i);
        ch = dec[1:0];
        req = wb_cyc_i & wb_stb_i & ~state_reg.ack;
        state_next = state_reg;
        state_next.clk_s1 = transmit_line_clock;
        state_next.clk_s2 = state_reg.clk_s1;
        state_next.pos_s1 = positive_rail_input;
        state_next.pos_s2 = state_reg.pos_s1;
        state_next.neg_s1 = negative_rail_input;
        state_next.neg_s2 = state_reg.neg_s1;
        // Every access, mapped or not, is acknowledged so the bus never hangs.
        state_next.ack = req;
        state_next.rdata = 32'h0000_0000;
        if (req) begin
            unique case (dec[3:2])
                2'b01: begin
                    state_next.rdata = {24'h00_0000, state_reg.tx_ctrl[ch]};
                    if (wb_we_i && wb_sel_i[0]) begin
                        state_next.tx_ctrl[ch] = wb_dat_i[7:0] & tcc_pkg::TX_CTRL_MASK;
                    end
                end
                2'b10: begin
                    state_next.rdata = {24'h00_0000, state_reg.rx_ctrl[ch]};
                    if (wb_we_i && wb_sel_i[0]) begin
                        state_next.rx_ctrl[ch] = wb_dat_i[7:0] & 8'h3f;
                    end
                end
                2'b11: begin
                    state_next.rdata = {24'h00_0000, state_reg.mode[ch]};
                    if (wb_we_i && wb_sel_i[0]) begin
                        state_next.mode[ch] = wb_dat_i[7:0] & tcc_pkg::MODE_MASK;
                    end
                end
                2'b00: begin
                    state_next.rdata = 32'h0000_0000;
                end
            endcase
        end
        if (!reset_n) begin
            state_next = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        state_reg <= state_next;
    end

    assign wb_ack_o = state_reg.ack;
    assign wb_dat_o = state_reg.rdata;

    // Each channel takes only its own register, so edge choice is per channel.
    for (genvar g = 0; g < tcc_pkg::NUM_CH; g++) begin : g_ch
        tcc_pkg::tcc_cfg_s  cfg;
        tcc_pkg::tcc_rail_s rail;
        tcc_pkg::tcc_rail_s out;
        assign cfg.mon_internal = state_reg.tx_ctrl[g][tcc_pkg::BIT_MON_SEL];
        assign cfg.err_insert   = state_reg.tx_ctrl[g][tcc_pkg::BIT_ERR_INSERT];
        assign cfg.all_ones     = state_reg.tx_ctrl[g][tcc_pkg::BIT_ALL_ONES];
        assign cfg.edge_rising  = state_reg.tx_ctrl[g][tcc_pkg::BIT_EDGE_SEL];
        assign cfg.buildout_on  = state_reg.tx_ctrl[g][tcc_pkg::BIT_BUILDOUT];
        assign cfg.e3_mode      = state_reg.mode[g][tcc_pkg::BIT_E3_MODE];
        assign cfg.prbs_gen_en  = state_reg.mode[g][tcc_pkg::BIT_PRBS_GEN_EN];
        assign cfg.prbs_rx_en   = state_reg.mode[g][tcc_pkg::BIT_PRBS_RX_EN];
        assign rail.pos = state_reg.pos_s2[g];
        assign rail.neg = state_reg.neg_s2[g];
        tcc_channel tcc_channel_inst (
            .sys_clk          (sys_clk),
            .reset_n          (reset_n),
            .cfg              (cfg),
            .line_clk_sync    (state_reg.clk_s2[g]),
            .rail_sync        (rail),
            .line_out         (out),
            .line_strobe      (line_strobe[g]),
            .error_inject     (error_inject[g]),
            .buildout_enable  (buildout_enable[g]),
            .monitor_internal (monitor_internal[g])
        );
        assign line_pos[g] = out.pos;
        assign line_neg[g] = out.neg;
    end

endmodule
`default_nettype wire

/* pkg/tcc_pkg.sv */
// Package with register map, field layout and carriers for the transmit channel control block.
package tcc_pkg;

    localparam int          NUM_CH          = 3;
    localparam int          REG_IDX_W       = 8;

    // Printed register indices; byte address is four times the index.
    localparam logic [7:0]  TX_CTRL_IDX_CH0 = 8'h04;
    localparam logic [7:0]  TX_CTRL_IDX_CH1 = 8'h0c;
    localparam logic [7:0]  TX_CTRL_IDX_CH2 = 8'h14;
    localparam logic [7:0]  RX_CTRL_IDX_CH0 = 8'h05;
    // Index of the extra mode register holding per-channel rate and PRBS enables.
    localparam logic [7:0]  MODE_IDX_CH0    = 8'h06;
    localparam logic [7:0]  CH_STRIDE       = 8'h08;

    localparam int          BIT_BUILDOUT    = 0;
    localparam int          BIT_EDGE_SEL    = 1;
    localparam int          BIT_ALL_ONES    = 2;
    localparam int          BIT_ERR_INSERT  = 4;
    localparam int          BIT_MON_SEL     = 5;
    localparam logic [7:0]  TX_CTRL_MASK    = 8'h37;
    localparam logic [7:0]  TX_CTRL_RESET   = 8'h00;

    // Mode register fields.
    localparam int          BIT_E3_MODE     = 0;
    localparam int          BIT_PRBS_GEN_EN = 1;
    localparam int          BIT_PRBS_RX_EN  = 2;
    localparam logic [7:0]  MODE_MASK       = 8'h07;
    localparam logic [7:0]  MODE_RESET      = 8'h00;

    typedef struct packed {
        logic       pos;
        logic       neg;
    } tcc_rail_s;

    typedef struct packed {
        logic       mon_internal;
        logic       err_insert;
        logic       all_ones;
        logic       edge_rising;
        logic       buildout_on;
        logic       e3_mode;
        logic       prbs_gen_en;
        logic       prbs_rx_en;
    } tcc_cfg_s;

endpackage

/* tb/tcc_framer_model.sv */
// Behavioural system-side framer driving link clock and rail data on all channels.
`timescale 1ns/1ns
`default_nettype none
module tcc_framer_model (
    input  wire logic               run,
    input  wire tcc_pkg::tcc_rail_s pat,
    output var  logic [2:0]         line_clk,
    output var  logic [2:0]         pos,
    output var  logic [2:0]         neg
);
    // Rails change a quarter period after each clock edge, so rising and falling samples see opposite values.
    initial begin
        line_clk = 3'h0;
        pos = 3'h0;
        neg = 3'h7;
        // Start one nanosecond off the system clock edge so pin changes never race its sampling flops.
        wait (run === 1'b1);
        #1;
        forever begin
            line_clk = 3'h7;
            #8;
            pos = {3{pat.pos}};
            neg = {3{pat.neg}};
            #8;
            line_clk = 3'h0;
            #8;
            pos = {3{~pat.pos}};
            neg = {3{~pat.neg}};
            #8;
        end
    end
endmodule
`default_nettype wire

/* tb/tcc_properties.sv */
// Assertion checker for the transmit channel control bank, bound to its top module.
`timescale 1ns/1ns
`default_nettype none
module tcc_properties (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    input  wire logic [2:0]  line_pos,
    input  wire logic [2:0]  line_strobe,
    input  wire logic [2:0]  error_inject,
    input  wire logic [2:0]  buildout_enable,
    input  wire logic [2:0]  monitor_internal
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered in one cycle");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    read_unused_a: assert property (wb_dat_o[31:6] == 26'h0) else $error("unused read bits not zero");
    reset_state_a: assert property (disable iff (1'b0) !reset_n |=> (wb_ack_o == 1'b0 && line_strobe == 3'h0
        && error_inject == 3'h0 && buildout_enable == 3'h0 && monitor_internal == 3'h0)) else $error("reset state");
    inject_strobe_a: assert property ((error_inject & ~line_strobe) == 3'h0) else $error("inject off strobe");
    strobe_pulse_a: assert property ((line_strobe & $past(line_strobe)) == 3'h0) else $error("strobe too long");
    line_hold_a: assert property (((line_pos ^ $past(line_pos)) & ~line_strobe) == 3'h0)
        else $error("line data moved without strobe");
    buildout_cause_a: assert property (buildout_enable != $past(buildout_enable) |-> $past(wb_ack_o, 1)
        || $past(wb_ack_o, 2) || wb_ack_o) else $error("buildout changed without write");
    monitor_cause_a: assert property ($changed(monitor_internal) |-> $past(wb_ack_o, 1)
        || $past(wb_ack_o, 2) || wb_ack_o) else $error("monitor select changed without write");
endmodule
bind tcc_top tcc_properties tcc_properties_inst (.sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .line_pos(line_pos), .line_strobe(line_strobe),
    .error_inject(error_inject), .buildout_enable(buildout_enable), .monitor_internal(monitor_internal));
`default_nettype wire

/* tb/tcc_top_bench.sv */
// Self-checking bench for the transmit channel control bank.
`timescale 1ns/1ns
`default_nettype none
module tcc_top_bench;
    logic               sys_clk = 1'b0;
    logic               reset_n = 1'b0;
    logic               wb_cyc_i = 1'b0;
    logic               wb_stb_i = 1'b0;
    logic               wb_we_i = 1'b0;
    logic [3:0]         wb_sel_i = 4'h0;
    logic [31:0]        rd0;
    logic [31:0]        wb_adr_i = 32'h0;
    logic [31:0]        wb_dat_i = 32'h0;
    logic [31:0]        wb_dat_o;
    logic               wb_ack_o;
    logic [2:0]         tlc, prail, nrail, line_pos, line_neg, line_strobe, error_inject, buildout_enable, mon;
    logic               link_en = 1'b0;
    tcc_pkg::tcc_rail_s pat = 2'b10;
    logic [7:0]         tx [3] = '{8'h04, 8'h0c, 8'h14};
    int                 fails = 0;
    int                 comparisons = 0;
    int                 inj_cnt = 0;
    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (error_inject[0] === 1'b1) inj_cnt++;
    tcc_framer_model tcc_framer_model_inst (.run(link_en), .pat(pat), .line_clk(tlc), .pos(prail), .neg(nrail));
    tcc_top tcc_top_inst (.sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .transmit_line_clock(tlc), .positive_rail_input(prail), .negative_rail_input(nrail),
        .line_pos(line_pos), .line_neg(line_neg), .line_strobe(line_strobe), .error_inject(error_inject),
        .buildout_enable(buildout_enable), .monitor_internal(mon));
    task automatic finish_test();
        if (fails == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic [7:0] idx, input logic we, input logic [3:0] sel, input logic [7:0] d,
                      output logic [31:0] rd);
        int n;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= sel;
        wb_adr_i <= {22'h0, idx, 2'b00};
        wb_dat_i <= {24'h0, d};
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        wb_sel_i <= 4'h0;
        if (wb_ack_o !== 1'b1) begin
            fails++;
            finish_test();
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] rd;
        wb(idx, 1'b1, 4'h1, d, rd);
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        wb(idx, 1'b0, 4'hf, 8'h00, rd);
        check(rd, exp);
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        link_en <= 1'b1;
        for (int c = 0; c < 3; c++) rdc(tx[c], 32'h0);
        wr(tx[0], 8'hff);
        rdc(tx[0], 32'h37);
        rdc(tx[1], 32'h0);
        wb(tx[1], 1'b1, 4'he, 8'h21, rd0);
        rdc(tx[1], 32'h0);
        wr(8'h07, 8'hff);
        rdc(8'h07, 32'h0);
        repeat (3) @(posedge sys_clk);
        check(32'({buildout_enable, mon}), 32'h09);
        wr(8'h06, 8'h01);
        repeat (3) @(posedge sys_clk);
        check(32'(buildout_enable), 32'h0);
        wr(8'h06, 8'h00);
        wr(tx[0], 8'h00);
        wr(tx[1], 8'h02);
        wr(tx[2], 8'h06);
        repeat (40) @(posedge sys_clk);
        check(32'({line_pos, line_neg}), 32'h2a);
        check(inj_cnt, 0);
        wr(tx[2], 8'h02);
        repeat (40) @(posedge sys_clk);
        check(32'({line_pos, line_neg}), 32'h0e);
        wr(8'h06, 8'h06);
        wr(tx[0], 8'h10);
        repeat (80) @(posedge sys_clk);
        check(inj_cnt, 1);
        wr(tx[0], 8'h00);
        wr(tx[0], 8'h10);
        repeat (40) @(posedge sys_clk);
        check(inj_cnt, 2);
        wr(tx[0], 8'h00);
        wr(8'h06, 8'h02);
        wr(tx[0], 8'h10);
        repeat (40) @(posedge sys_clk);
        check(inj_cnt, 2);
        finish_test();
    end
endmodule
`default_nettype wire
